/* File: design/icrp_pkg.sv */
package icrp_pkg;
   // Core clock and the loop settling delay
   localparam int unsigned CORE_CLK_HZ     = 25_000_000;
   localparam int unsigned PLL_DELAY_MS    = 10;
   localparam int unsigned PLL_DELAY_CYC   = (CORE_CLK_HZ / 1000) * PLL_DELAY_MS;

   // Fixed upper part of the slave address and the general call byte
   localparam logic [4:0]  SLV_ADDR_HI     = 5'h06;
   localparam logic [7:0]  GEN_CALL_BYTE   = 8'h00;

   // Control port register indexes
   localparam logic [7:0]  REG_PWR         = 8'h00;
   localparam logic [7:0]  REG_STATUS      = 8'h01;
   localparam logic [7:0]  REG_SETTING     = 8'h02;
   localparam logic [7:0]  REG_MEM_SEL     = 8'h03;
   localparam logic [7:0]  REG_MEM_ADDR_HI = 8'h04;
   localparam logic [7:0]  REG_MEM_ADDR_LO = 8'h05;
   localparam logic [7:0]  REG_MEM_DATA    = 8'h06;

   // Power control bit positions
   localparam int unsigned PWR_ADC_L_BIT   = 0;
   localparam int unsigned PWR_ADC_R_BIT   = 1;
   localparam int unsigned PWR_PLL_BIT     = 2;
   localparam int unsigned PWR_DSP_BIT     = 3;

   // Values after reset
   localparam logic [7:0]  PWR_RST         = 8'h00;
   localparam logic [7:0]  SETTING_RST     = 8'h00;
   localparam logic [1:0]  MEM_SEL_RST     = 2'h0;

   // Embedded signal processor storage
   localparam int unsigned INSTR_DEPTH     = 512;
   localparam int unsigned DATA_DEPTH      = 256;
   localparam int unsigned COEF_DEPTH      = 128;
   localparam int unsigned MEM_W           = 16;
   localparam int unsigned SAMPLE_W        = 16;
   localparam logic [1:0]  MEM_SEL_INSTR   = 2'h0;
   localparam logic [1:0]  MEM_SEL_DATA    = 2'h1;
   localparam logic [1:0]  MEM_SEL_COEF    = 2'h2;

   // Control port states, Gray coded along the write path
   typedef enum logic [3:0] {
      ICRP_IDLE     = 4'h0,
      ICRP_ADDR     = 4'h1,
      ICRP_ADDR_ACK = 4'h3,
      ICRP_REG      = 4'h2,
      ICRP_REG_ACK  = 4'h6,
      ICRP_WDATA    = 4'h7,
      ICRP_WACK     = 4'h5,
      ICRP_RDATA    = 4'h4,
      ICRP_RACK     = 4'hc,
      ICRP_WAIT     = 4'hd
   } icrp_state_e;
endpackage

/* File: design/icrp_pll_timer.sv */
module icrp_pll_timer #(
   parameter int unsigned DELAY_CYC = 16
) (
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   input  wire logic i_pll_on,
   output logic      o_clk_valid
);
   localparam int unsigned CW = $clog2(DELAY_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);

   logic [CW-1:0] cnt_reg;

   // Restarts on every power-up so a short off pulse never passes unsettled clocks
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg     <= '0;
         o_clk_valid <= 1'b0;
      end else if (!i_pll_on) begin
         cnt_reg     <= '0;
         o_clk_valid <= 1'b0;
      end else if (!o_clk_valid) begin
         if (cnt_reg == LAST) begin
            o_clk_valid <= 1'b1;
         end
         cnt_reg <= cnt_reg + CW'(1);
      end
   end
endmodule

/* File: design/icrp_top.sv */
module icrp_top
   import icrp_pkg::*;
#(
   parameter int unsigned PLL_DELAY = icrp_pkg::PLL_DELAY_CYC
) (
   input  wire logic                          i_core_clk,
   input  wire logic                          i_rst_n,
   input  wire logic                          i_scl,
   input  wire logic                          i_sda,
   input  wire logic                          i_addr_select_hi_pin,
   input  wire logic                          i_addr_select_lo_pin,
   input  wire logic [8:0]                    i_instr_idx,
   input  wire logic [6:0]                    i_coef_idx,
   input  wire logic [7:0]                    i_data_idx,
   input  wire logic [icrp_pkg::SAMPLE_W-1:0] i_sample_l,
   input  wire logic [icrp_pkg::SAMPLE_W-1:0] i_sample_r,
   input  wire logic                          i_sample_valid,
   output logic                               o_sda_out,
   output logic                               o_sda_oe,
   output logic                               o_scl_out,
   output logic                               o_scl_oe,
   output logic                               o_pwr_adc_l,
   output logic                               o_pwr_adc_r,
   output logic                               o_pwr_pll,
   output logic                               o_pwr_dsp,
   output logic                               o_clk_valid,
   output logic [7:0]                         o_setting,
   output logic [icrp_pkg::MEM_W-1:0]         o_instr,
   output logic [icrp_pkg::MEM_W-1:0]         o_coef,
   output logic [icrp_pkg::MEM_W-1:0]         o_data,
   output logic [icrp_pkg::SAMPLE_W-1:0]      o_sample_l,
   output logic [icrp_pkg::SAMPLE_W-1:0]      o_sample_r,
   output logic                               o_sample_valid
);
   import icrp_pkg::*;

   icrp_state_e    state_reg;
   logic           scl_q_reg;
   logic           sda_q_reg;
   logic [7:0]     shift_reg;
   logic [3:0]     cnt_reg;
   logic           rnw_reg;
   logic           gc_reg;
   logic           mack_reg;
   logic [7:0]     ptr_reg;
   logic [7:0]     pwr_reg;
   logic [7:0]     setting_reg;
   logic [1:0]     mem_sel_reg;
   logic [8:0]     mem_addr_reg;
   logic [7:0]     hold_reg;
   logic           phase_reg;
   logic [MEM_W-1:0] instr_mem [INSTR_DEPTH];
   logic [MEM_W-1:0] data_mem  [DATA_DEPTH];
   logic [MEM_W-1:0] coef_mem  [COEF_DEPTH];

   logic           scl_rise;
   logic           scl_fall;
   logic           start_cond;
   logic           stop_cond;
   logic [6:0]     own_addr;
   logic           addr_hit;
   logic           ptr_load;
   logic           reg_wr;
   logic           rd_next;
   logic [7:0]     rd_byte;
   logic [2:0]     tx_idx;
   logic [MEM_W-1:0] mem_word;

   // Inputs are synchronous; at 25 MHz the shortest fast-mode phase spans many samples
   assign scl_rise   = i_scl & ~scl_q_reg;
   assign scl_fall   = ~i_scl & scl_q_reg;
   assign start_cond = i_scl & scl_q_reg & sda_q_reg & ~i_sda;
   assign stop_cond  = i_scl & scl_q_reg & ~sda_q_reg & i_sda;

   assign own_addr = {SLV_ADDR_HI, i_addr_select_hi_pin, i_addr_select_lo_pin};
   assign addr_hit = (shift_reg[7:1] == own_addr) || (shift_reg == GEN_CALL_BYTE);

   assign ptr_load = scl_fall && (state_reg == ICRP_REG) && (cnt_reg == 4'h8) && !gc_reg;
   assign reg_wr   = scl_fall && (state_reg == ICRP_WDATA) && (cnt_reg == 4'h8) && !gc_reg;
   assign rd_next  = scl_rise && (state_reg == ICRP_RACK) && !i_sda;
   assign tx_idx   = 3'h7 - cnt_reg[2:0];
   assign mem_word = {hold_reg, shift_reg};

   always_comb begin
      unique case (ptr_reg)
         REG_PWR:         rd_byte = pwr_reg;
         REG_STATUS:      rd_byte = {7'h00, o_clk_valid};
         REG_SETTING:     rd_byte = setting_reg;
         REG_MEM_SEL:     rd_byte = {6'h00, mem_sel_reg};
         REG_MEM_ADDR_HI: rd_byte = {7'h00, mem_addr_reg[8]};
         REG_MEM_ADDR_LO: rd_byte = mem_addr_reg[7:0];
         default:         rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= i_scl;
         sda_q_reg <= i_sda;
      end
   end

   // Open-drain pins: data only ever pulled low, clock never driven
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sda_out <= 1'b0;
         o_scl_out <= 1'b0;
         o_scl_oe  <= 1'b0;
      end else begin
         o_sda_out <= 1'b0;
         o_scl_out <= 1'b0;
         o_scl_oe  <= 1'b0;
      end
   end

   // Bus state; reset returns it to a clean idle so accesses start aligned
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= ICRP_IDLE;
         shift_reg <= 8'h00;
         cnt_reg   <= 4'h0;
         rnw_reg   <= 1'b0;
         gc_reg    <= 1'b0;
         mack_reg  <= 1'b0;
         o_sda_oe  <= 1'b0;
      end else if (start_cond) begin
         state_reg <= ICRP_ADDR;
         cnt_reg   <= 4'h0;
         o_sda_oe  <= 1'b0;
      end else if (stop_cond) begin
         state_reg <= ICRP_IDLE;
         o_sda_oe  <= 1'b0;
      end else if (scl_rise) begin
         unique case (state_reg)
            ICRP_ADDR, ICRP_REG, ICRP_WDATA: begin
               shift_reg <= {shift_reg[6:0], i_sda};
               cnt_reg   <= cnt_reg + 4'h1;
            end
            ICRP_RDATA: cnt_reg <= cnt_reg + 4'h1;
            ICRP_RACK:  mack_reg <= ~i_sda;
            default: ;
         endcase
      end else if (scl_fall) begin
         unique case (state_reg)
            ICRP_ADDR: begin
               if (cnt_reg == 4'h8) begin
                  if (addr_hit) begin
                     state_reg <= ICRP_ADDR_ACK;
                     o_sda_oe  <= 1'b1;
                     rnw_reg   <= shift_reg[0];
                     gc_reg    <= (shift_reg == GEN_CALL_BYTE);
                  end else begin
                     state_reg <= ICRP_WAIT;
                  end
               end
            end
            ICRP_ADDR_ACK: begin
               cnt_reg <= 4'h0;
               if (rnw_reg) begin
                  state_reg <= ICRP_RDATA;
                  o_sda_oe  <= ~rd_byte[7];
               end else begin
                  state_reg <= ICRP_REG;
                  o_sda_oe  <= 1'b0;
               end
            end
            ICRP_REG: begin
               if (cnt_reg == 4'h8) begin
                  state_reg <= ICRP_REG_ACK;
                  o_sda_oe  <= 1'b1;
               end
            end
            ICRP_WDATA: begin
               if (cnt_reg == 4'h8) begin
                  state_reg <= ICRP_WACK;
                  o_sda_oe  <= 1'b1;
               end
            end
            ICRP_REG_ACK, ICRP_WACK: begin
               state_reg <= ICRP_WDATA;
               cnt_reg   <= 4'h0;
               o_sda_oe  <= 1'b0;
            end
            ICRP_RDATA: begin
               if (cnt_reg == 4'h8) begin
                  state_reg <= ICRP_RACK;
                  o_sda_oe  <= 1'b0;
               end else begin
                  o_sda_oe  <= ~rd_byte[tx_idx];
               end
            end
            ICRP_RACK: begin
               cnt_reg <= 4'h0;
               if (mack_reg) begin
                  state_reg <= ICRP_RDATA;
                  o_sda_oe  <= ~rd_byte[7];
               end else begin
                  state_reg <= ICRP_WAIT;
                  o_sda_oe  <= 1'b0;
               end
            end
            ICRP_IDLE, ICRP_WAIT: ;
            default: begin
               state_reg <= ICRP_IDLE;
               o_sda_oe  <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ptr_reg <= 8'h00;
      end else if (ptr_load) begin
         ptr_reg <= shift_reg;
      end else if (reg_wr || rd_next) begin
         ptr_reg <= ptr_reg + 8'h01;
      end
   end

   // Power bits only gate blocks; nothing here clears other settings on power-down
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pwr_reg     <= PWR_RST;
         setting_reg <= SETTING_RST;
      end else if (reg_wr) begin
         if (ptr_reg == REG_PWR) begin
            pwr_reg <= shift_reg;
         end
         if (ptr_reg == REG_SETTING) begin
            setting_reg <= shift_reg;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mem_sel_reg  <= MEM_SEL_RST;
         mem_addr_reg <= 9'h000;
         hold_reg     <= 8'h00;
         phase_reg    <= 1'b0;
      end else if (reg_wr) begin
         unique case (ptr_reg)
            REG_MEM_SEL: begin
               mem_sel_reg <= shift_reg[1:0];
               phase_reg   <= 1'b0;
            end
            REG_MEM_ADDR_HI: begin
               mem_addr_reg[8] <= shift_reg[0];
               phase_reg       <= 1'b0;
            end
            REG_MEM_ADDR_LO: begin
               mem_addr_reg[7:0] <= shift_reg;
               phase_reg         <= 1'b0;
            end
            REG_MEM_DATA: begin
               if (!phase_reg) begin
                  hold_reg <= shift_reg;
               end else begin
                  mem_addr_reg <= mem_addr_reg + 9'h001;
               end
               phase_reg <= ~phase_reg;
            end
            default: ;
         endcase
      end
   end

   // Program storage has no reset: contents are lost with power and must be reloaded
   always_ff @(posedge i_core_clk) begin
      if (reg_wr && (ptr_reg == REG_MEM_DATA) && phase_reg) begin
         unique case (mem_sel_reg)
            MEM_SEL_INSTR: instr_mem[mem_addr_reg] <= mem_word;
            MEM_SEL_DATA:  data_mem[mem_addr_reg[7:0]] <= mem_word;
            MEM_SEL_COEF:  coef_mem[mem_addr_reg[6:0]] <= mem_word;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      o_instr <= instr_mem[i_instr_idx];
      o_coef  <= coef_mem[i_coef_idx];
      o_data  <= data_mem[i_data_idx];
   end

   assign o_pwr_adc_l = pwr_reg[PWR_ADC_L_BIT];
   assign o_pwr_adc_r = pwr_reg[PWR_ADC_R_BIT];
   assign o_pwr_pll   = pwr_reg[PWR_PLL_BIT];
   assign o_pwr_dsp   = pwr_reg[PWR_DSP_BIT];
   assign o_setting   = setting_reg;

   // One register stage only, keeping group delay to a single cycle
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_sample_l     <= '0;
         o_sample_r     <= '0;
         o_sample_valid <= 1'b0;
      end else begin
         o_sample_valid <= i_sample_valid & pwr_reg[PWR_DSP_BIT] & o_clk_valid;
         if (i_sample_valid) begin
            o_sample_l <= i_sample_l;
            o_sample_r <= i_sample_r;
         end
      end
   end

   icrp_pll_timer #(
      .DELAY_CYC (PLL_DELAY)
   ) u_pll_timer (
      .i_core_clk  (i_core_clk),
      .i_rst_n     (i_rst_n),
      .i_pll_on    (pwr_reg[PWR_PLL_BIT]),
      .o_clk_valid (o_clk_valid)
   );
endmodule

/* File: sim/icrp_top_asserts.sv */
module icrp_top_asserts #(
   parameter int unsigned PLL_DELAY = 16
) (
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic        i_scl,
   input wire logic        i_sample_valid,
   input wire logic [15:0] i_sample_l,
   input wire logic        o_sda_out,
   input wire logic        o_sda_oe,
   input wire logic        o_scl_out,
   input wire logic        o_scl_oe,
   input wire logic        o_pwr_adc_l,
   input wire logic        o_pwr_adc_r,
   input wire logic        o_pwr_pll,
   input wire logic        o_pwr_dsp,
   input wire logic        o_clk_valid,
   input wire logic [15:0] o_sample_l,
   input wire logic        o_sample_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned pll_cnt_reg;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_fwd;
      o_sample_valid && o_sample_l == $past(i_sample_l);
   endsequence
   sequence s_clk_gone;
      ##[0:1] !o_clk_valid ##1 !o_clk_valid;
   endsequence
   // Saturates just past the delay so the arrival check sees one exact value
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pll_cnt_reg <= 0;
      end else if (!o_pwr_pll) begin
         pll_cnt_reg <= 0;
      end else if (pll_cnt_reg < PLL_DELAY + 4) begin
         pll_cnt_reg <= pll_cnt_reg + 1;
      end
   end
   a_scl_never_driven: assert property (!o_scl_oe && !o_scl_out) else $error("bus clock driven");
   a_sda_drive_low: assert property (!o_sda_out) else $error("data driven high");
   a_oe_low_phase: assert property ($rose(o_sda_oe) |-> !i_scl) else $error("data taken while clock high");
   a_reset_all_off: assert property ($rose(i_rst_n) |-> !(o_pwr_adc_l || o_pwr_adc_r || o_pwr_pll
      || o_pwr_dsp || o_clk_valid || o_sda_oe)) else $error("block powered after reset");
   // The timer raises clock valid on the edge where this counter reaches the delay
   a_clk_gate_count: assert property (o_clk_valid && o_pwr_pll |-> pll_cnt_reg >= PLL_DELAY)
      else $error("clock valid too early");
   a_clk_valid_on: assert property (pll_cnt_reg == PLL_DELAY |-> o_clk_valid) else $error("clock valid late");
   a_pll_off_drops: assert property ($fell(o_pwr_pll) |-> s_clk_gone) else $error("clock valid kept");
   a_sample_forward: assert property (i_sample_valid && o_pwr_dsp && o_clk_valid |=> s_fwd)
      else $error("sample not passed");
   a_sample_blocked: assert property (!(i_sample_valid && o_pwr_dsp && o_clk_valid) |=> !o_sample_valid)
      else $error("sample passed while gated");
endmodule

bind icrp_top icrp_top_asserts #(.PLL_DELAY(PLL_DELAY)) icrp_top_asserts_inst (
   .i_core_clk, .i_rst_n, .i_scl, .i_sample_valid, .i_sample_l, .o_sda_out, .o_sda_oe, .o_scl_out,
   .o_scl_oe, .o_pwr_adc_l, .o_pwr_adc_r, .o_pwr_pll, .o_pwr_dsp, .o_clk_valid, .o_sample_l, .o_sample_valid
);

/* File: sim/icrp_i2c_master.sv */
module icrp_i2c_master (
   input  wire logic i_core_clk,
   input  wire logic i_sda,
   output logic      o_scl_low,
   output logic      o_sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   // Only this side makes the bus clock; each phase lasts at least 3 core clocks
   task automatic bit_io(input logic b, output logic s);
      hold(3);
      o_sda_low <= ~b;
      hold(3);
      o_scl_low <= 1'b0;
      hold(4);
      s = i_sda;
      o_scl_low <= 1'b1;
   endtask
   // Also serves as repeated start when the clock is low
   task automatic start();
      hold(3);
      o_sda_low <= 1'b0;
      hold(3);
      o_scl_low <= 1'b0;
      hold(4);
      o_sda_low <= 1'b1;
      hold(4);
      o_scl_low <= 1'b1;
   endtask
   task automatic stop();
      hold(3);
      o_sda_low <= 1'b1;
      hold(3);
      o_scl_low <= 1'b0;
      hold(4);
      o_sda_low <= 1'b0;
      hold(4);
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic recv_byte(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(~mack, s);
   endtask
endmodule

/* File: sim/icrp_top_tb.sv */
module icrp_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import icrp_pkg::*;
   localparam int unsigned DLY = 600;
   logic        i_core_clk = 1'b0;
   logic        i_rst_n, i_sample_valid, m_scl_low, m_sda_low, ok;
   logic [1:0]  pins;
   logic [8:0]  i_instr_idx, a;
   logic [6:0]  i_coef_idx;
   logic [7:0]  i_data_idx, v, pv, sv;
   logic [15:0] i_sample_l, i_sample_r, w;
   logic        o_sda_out, o_sda_oe, o_scl_out, o_scl_oe, o_pwr_adc_l, o_pwr_adc_r, o_pwr_pll, o_pwr_dsp;
   logic        o_clk_valid, o_sample_valid;
   logic [7:0]  o_setting;
   logic [15:0] o_instr, o_coef, o_data, o_sample_l, o_sample_r;
   logic [7:0]  q[$];
   int          errors = 0, tests_run = 0;
   // Open drain wires: pulled high unless someone pulls low
   wire logic   i_scl = ~m_scl_low & ~(o_scl_oe & ~o_scl_out);
   wire logic   i_sda = ~m_sda_low & ~(o_sda_oe & ~o_sda_out);
   always #20 i_core_clk = ~i_core_clk;
   icrp_top #(.PLL_DELAY(DLY)) icrp_top_inst (
      .i_core_clk, .i_rst_n, .i_scl, .i_sda, .i_addr_select_hi_pin(pins[1]), .i_addr_select_lo_pin(pins[0]),
      .i_instr_idx, .i_coef_idx, .i_data_idx, .i_sample_l, .i_sample_r, .i_sample_valid, .o_sda_out,
      .o_sda_oe, .o_scl_out, .o_scl_oe, .o_pwr_adc_l, .o_pwr_adc_r, .o_pwr_pll, .o_pwr_dsp, .o_clk_valid,
      .o_setting, .o_instr, .o_coef, .o_data, .o_sample_l, .o_sample_r, .o_sample_valid
   );
   icrp_i2c_master icrp_i2c_master_inst (.i_core_clk, .i_sda, .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   function automatic logic [6:0] dev(input logic [1:0] p);
      return {5'h06, p};
   endfunction
   task automatic reset_dut();
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      repeat (10) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      #1;
      check("powers after reset", {o_pwr_dsp, o_pwr_pll, o_pwr_adc_r, o_pwr_adc_l, o_clk_valid}, 5'h00);
      check("setting after reset", o_setting, SETTING_RST);
   endtask
   task automatic wr(input logic [6:0] ad, input logic [7:0] idx, input logic [7:0] d[$]);
      logic ack;
      icrp_i2c_master_inst.start();
      icrp_i2c_master_inst.send_byte({ad, 1'b0}, ok);
      if (ok) begin
         icrp_i2c_master_inst.send_byte(idx, ack);
         ok = ok & ack;
         foreach (d[i]) begin
            icrp_i2c_master_inst.send_byte(d[i], ack);
            ok = ok & ack;
         end
      end
      icrp_i2c_master_inst.stop();
      #1;
   endtask
   task automatic rd(input logic [7:0] idx, input int n);
      logic ack;
      logic [7:0] b;
      q = {};
      icrp_i2c_master_inst.start();
      icrp_i2c_master_inst.send_byte({dev(pins), 1'b0}, ack);
      icrp_i2c_master_inst.send_byte(idx, ack);
      icrp_i2c_master_inst.start();
      icrp_i2c_master_inst.send_byte({dev(pins), 1'b1}, ack);
      for (int i = 0; i < n; i++) begin
         icrp_i2c_master_inst.recv_byte(i < n - 1, b);
         q.push_back(b);
      end
      icrp_i2c_master_inst.stop();
      #1;
   endtask
   task automatic pulse();
      @(posedge i_core_clk);
      i_sample_l <= 16'($urandom);
      i_sample_r <= 16'($urandom);
      i_sample_valid <= 1'b1;
      @(posedge i_core_clk);
      i_sample_valid <= 1'b0;
      #1;
   endtask
   initial begin
      i_rst_n = 1'b0;
      pins = 2'h0;
      i_instr_idx = 9'h000;
      i_coef_idx = 7'h00;
      i_data_idx = 8'h00;
      i_sample_l = 16'h0000;
      i_sample_r = 16'h0000;
      i_sample_valid = 1'b0;
      void'($urandom(92496));
      reset_dut();
      for (int p = 0; p < 4; p++) begin
         @(posedge i_core_clk);
         pins <= 2'(p);
         v = 8'($urandom);
         wr(dev(2'(p)), REG_SETTING, '{v});
         check("own address ack", ok, 1'b1);
         check("setting written", o_setting, v);
         wr(dev(2'(p) ^ 2'($urandom_range(1, 3))), REG_SETTING, '{~v});
         check("other address ack", ok, 1'b0);
         wr({5'h06 ^ (5'h01 << $urandom_range(0, 4)), 2'(p)}, REG_SETTING, '{~v});
         check("fixed bits ack", ok, 1'b0);
         check("setting kept", o_setting, v);
      end
      wr(7'h00, REG_SETTING, '{~v, v});
      check("general call ack", ok, 1'b1);
      check("general call ignored", o_setting, v);
      for (int b = 0; b < 4; b++) begin
         wr(dev(pins), REG_PWR, '{8'h01 << b});
         check("one block on", {o_pwr_dsp, o_pwr_pll, o_pwr_adc_r, o_pwr_adc_l}, 4'h1 << b);
         check("setting kept", o_setting, v);
      end
      pv = 8'($urandom) & 8'h0b;
      sv = 8'($urandom);
      wr(dev(pins), REG_PWR, '{pv, 8'hff, sv});
      check("power by increment", {o_pwr_dsp, o_pwr_pll, o_pwr_adc_r, o_pwr_adc_l}, pv[3:0]);
      check("setting by increment", o_setting, sv);
      rd(REG_PWR, 3);
      check("read power", q[0], pv);
      check("read status", q[1], 8'h00);
      check("read setting", q[2], sv);
      wr(dev(pins), REG_PWR, '{8'h0c});
      check("clock held back", o_clk_valid, 1'b0);
      rd(REG_STATUS, 1);
      check("status while counting", q[0], 8'h00);
      repeat (DLY) @(posedge i_core_clk);
      #1;
      check("clock released", o_clk_valid, 1'b1);
      rd(REG_STATUS, 1);
      check("status after count", q[0], 8'h01);
      repeat (8) begin
         repeat ($urandom_range(0, 2)) @(posedge i_core_clk);
         pulse();
         check("sample strobe", o_sample_valid, 1'b1);
         check("sample left", o_sample_l, i_sample_l);
         check("sample right", o_sample_r, i_sample_r);
      end
      wr(dev(pins), REG_PWR, '{8'h04});
      pulse();
      check("sample gated", o_sample_valid, 1'b0);
      wr(dev(pins), REG_PWR, '{8'h00});
      check("clock dropped", o_clk_valid, 1'b0);
      // Program load with all blocks powered down, one word at the top of each store
      for (int m = 0; m < 3; m++) begin
         a = (m == 0) ? 9'h1ff : (m == 1) ? 9'h0ff : 9'h07f;
         w = 16'($urandom);
         // The pointer steps past the data port after each byte, so the low byte needs its own write
         wr(dev(pins), REG_MEM_SEL, '{8'(m), 8'(a[8]), a[7:0], w[15:8]});
         wr(dev(pins), REG_MEM_DATA, '{w[7:0]});
         @(posedge i_core_clk);
         i_instr_idx <= a;
         i_data_idx <= a[7:0];
         i_coef_idx <= a[6:0];
         repeat (2) @(posedge i_core_clk);
         #1;
         check("memory top word", (m == 0) ? o_instr : (m == 1) ? o_data : o_coef, w);
      end
      reset_dut();
      test_done();
   end
   // Bus traffic needs about 10000 cycles; a hang stops well past that
   initial begin
      repeat (80000) @(posedge i_core_clk);
      errors++;
      test_done();
   end
endmodule
